// file: rct_timer.sv
// reload/capture timer: two 8-bit halves, reload, split and capture modes
// assumes a plain register port, synchronous inputs other than the two oscillators, and one core clock
//
// Functional notes
// [R01] count is two software-visible 8-bit halves
// [R02] mode from split and capture enable bits
// [R03] tick: core clock, clock/12, or ext/8
// [R04] external oscillator synchronised before dividing
// [R05] 16-bit mode reloads at 0xFFFF wrap
// [R06] 16-bit overflow sets high flag, interrupts
// [R07] low-byte wrap interrupts when low enable set
// [R08] split mode: two 8-bit reloading timers
// [R09] run bit gates only high half in split
// [R10] per-half tick from fast bit, ext select
// [R11] split mode sets each half's overflow flag
// [R12] split interrupts high, or either with enable
// [R13] overflow flags cleared only by software
// [R14] software reads both flags to find source
// [R15] capture mode, source bit picks the trigger
// [R16] capture 16-bit mode counts freely, wraps
// [R17] capture copies count into reload, interrupts
// [R18] capture split mode: two free 8-bit counters
// [R19] source 0 is frame start, 1 oscillator
// [R20] each trigger gives exactly one capture pulse
`timescale 1ns/100ps
module rct_timer
    import rct_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [RCT_AW-1:0] i_addr,    // register address
    input wire logic [RCT_DW-1:0] i_wdata,   // register write data
    input wire logic i_wr,                   // write strobe
    input wire logic i_rd,                   // read strobe
    input wire logic i_tmr_irq_en,           // timer interrupts enabled
    input wire logic i_ext_osc,              // external oscillator level
    input wire logic i_low_freq_osc,         // low_freq_osc level
    input wire logic i_usb_sof,              // start-of-frame strobe
    output logic [RCT_DW-1:0] o_rdata,       // read data, cycle after strobe
    output logic o_irq                       // interrupt request level
);

    // ************************************************************
    // state record
    // ************************************************************
    typedef struct packed {
        logic [RCT_DW-1:0] ctrl;      // control_reg
        logic [RCT_DW-1:0] reload_lo; // reload_low
        logic [RCT_DW-1:0] reload_hi; // reload_high
        logic [1:0] cksel;            // clock_select_reg fast bits
        logic [3:0] div12;            // core clock divider
        logic sys12_tick;             // core_clock / 12 pulse
        logic ext_s1;                 // ext osc sync stage 1
        logic ext_s2;                 // ext osc sync stage 2
        logic ext_prev;               // ext osc edge history
        logic [2:0] ext_cnt;          // ext osc edge divider
        logic ext8_tick;              // ext osc / 8 pulse
        logic lfo_s1;                 // oscillator sync stage 1
        logic lfo_s2;                 // oscillator sync stage 2
        logic lfo_prev;               // oscillator edge history
        logic sof_prev;               // frame strobe history
        logic cap_pulse;              // one capture per event
        logic [RCT_DW-1:0] rdata;     // read data register
        logic irq;                    // interrupt request
    } rct_state_t;

    rct_state_t s_q; // registered state
    rct_state_t s_d; // next state

    // ************************************************************
    // counter halves and their controls
    // ************************************************************
    logic [RCT_DW-1:0] lo_count; // count_low
    logic [RCT_DW-1:0] hi_count; // count_high
    logic lo_wrap;               // low half overflow this cycle
    logic hi_wrap;               // high half overflow this cycle
    logic lo_inc;                // low half increment
    logic hi_inc;                // high half increment
    logic lo_reload_now;         // low half reloads on wrap
    logic hi_reload_now;         // high half reloads on wrap
    logic lo_tick;               // low half tick
    logic hi_tick;               // high half tick
    logic wr_ctrl;               // decoded writes
    logic wr_clo;
    logic wr_chi;
    logic split;                 // split_mode_sel
    logic cap_en;                // capture_enable_bit
    logic run;                   // high_run_ctl
    logic trigger;               // raw capture trigger this cycle
    rct_mode_t mode;             // decoded operating mode

    assign wr_ctrl = i_wr && (i_addr == RCT_ADDR_CTRL);
    assign wr_clo = i_wr && (i_addr == RCT_ADDR_CLO);
    assign wr_chi = i_wr && (i_addr == RCT_ADDR_CHI);
    assign split = s_q.ctrl[RCT_CTL_SPLIT];
    assign cap_en = s_q.ctrl[RCT_CTL_CAP_EN];
    assign run = s_q.ctrl[RCT_CTL_RUN];

    // ************************************************************
    // mode decode
    // ************************************************************
    // two control bits, capture enable and split, choose one of four modes
    always_comb begin
        if (cap_en && split) begin
            mode = RCT_MODE_CAP8; // [R02] [R15]
        end else if (cap_en) begin
            mode = RCT_MODE_CAP16; // [R02] [R15]
        end else if (split) begin
            mode = RCT_MODE_SPLIT8; // [R02]
        end else begin
            mode = RCT_MODE_RELOAD16; // [R02]
        end
    end

    // per-half tick: fast bit wins, else ext select picks the divider
    always_comb begin
        lo_tick = s_q.cksel[RCT_CKS_LO_FAST] ? 1'b1 :
                  (s_q.ctrl[RCT_CTL_EXT_CLK] ? s_q.ext8_tick : s_q.sys12_tick); // [R03] [R10]
        hi_tick = s_q.cksel[RCT_CKS_HI_FAST] ? 1'b1 :
                  (s_q.ctrl[RCT_CTL_EXT_CLK] ? s_q.ext8_tick : s_q.sys12_tick); // [R03] [R10]
    end

    // increment and reload routing for each mode
    always_comb begin
        lo_inc = 1'b0;
        hi_inc = 1'b0;
        lo_reload_now = 1'b0;
        hi_reload_now = 1'b0;
        case (mode)
            RCT_MODE_RELOAD16: begin
                // 16-bit mode uses the low half's tick; the run bit gates both
                lo_inc = lo_tick && run;
                hi_inc = lo_wrap;              // [R01]
                lo_reload_now = hi_wrap;       // full wrap only [R05]
                hi_reload_now = 1'b1;          // [R05]
            end
            RCT_MODE_SPLIT8: begin
                lo_inc = lo_tick;              // low half always runs [R09]
                hi_inc = hi_tick && run;       // [R09]
                lo_reload_now = 1'b1;          // [R08]
                hi_reload_now = 1'b1;          // [R08]
            end
            RCT_MODE_CAP16: begin
                // free running: reload registers hold captures instead
                lo_inc = lo_tick && run;
                hi_inc = lo_wrap;              // [R16]
            end
            RCT_MODE_CAP8: begin
                lo_inc = lo_tick;              // [R18]
                hi_inc = hi_tick && run;       // [R18]
            end
            default: begin
                lo_inc = 1'b0;
            end
        endcase
    end

    // low half of the count
    rct_half8 #(
        .W(RCT_DW)
    ) u_lo (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_inc(lo_inc),
        .i_reload_now(lo_reload_now),
        .i_reload(s_q.reload_lo),
        .i_wr(wr_clo),
        .i_wdata(i_wdata),
        .o_count(lo_count),
        .o_wrap(lo_wrap)
    );

    // high half of the count
    rct_half8 #(
        .W(RCT_DW)
    ) u_hi (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_inc(hi_inc),
        .i_reload_now(hi_reload_now),
        .i_reload(s_q.reload_hi),
        .i_wr(wr_chi),
        .i_wdata(i_wdata),
        .o_count(hi_count),
        .o_wrap(hi_wrap)
    );

    // capture trigger by source select; edge detect on the synced oscillator level or the raw frame strobe
    always_comb begin
        if (s_q.ctrl[RCT_CTL_CAP_SRC] == RCT_SRC_LFO) begin
            trigger = s_q.lfo_s2 && !s_q.lfo_prev; // [R19]
        end else begin
            trigger = i_usb_sof && !s_q.sof_prev;  // [R19]
        end
    end

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        s_d = s_q;
        // core clock divide by twelve
        if (s_q.div12 == RCT_SYS_DIV_MAX) begin
            s_d.div12 = '0;
        end else begin
            s_d.div12 = s_q.div12 + RCT_SYS_DIV_ONE;
        end
        s_d.sys12_tick = (s_q.div12 == RCT_SYS_DIV_MAX); // [R03]
        // ext osc: two flops, then count rising edges by eight
        s_d.ext_s1 = i_ext_osc;     // [R04]
        s_d.ext_s2 = s_q.ext_s1;    // [R04]
        s_d.ext_prev = s_q.ext_s2;
        s_d.ext8_tick = 1'b0;
        if (s_q.ext_s2 && !s_q.ext_prev) begin
            s_d.ext_cnt = s_q.ext_cnt + RCT_EXT_DIV_ONE;
            s_d.ext8_tick = (s_q.ext_cnt == RCT_EXT_DIV_MAX); // [R03] [R04]
        end
        // oscillator and frame strobe histories
        s_d.lfo_s1 = i_low_freq_osc;
        s_d.lfo_s2 = s_q.lfo_s1;
        s_d.lfo_prev = s_q.lfo_s2;
        s_d.sof_prev = i_usb_sof;
        // one registered pulse per trigger edge, only in capture mode
        s_d.cap_pulse = trigger && cap_en; // [R15] [R20]
        // software register writes
        if (wr_ctrl) begin
            s_d.ctrl = i_wdata;
        end
        if (i_wr && (i_addr == RCT_ADDR_RLO)) begin
            s_d.reload_lo = i_wdata;
        end
        if (i_wr && (i_addr == RCT_ADDR_RHI)) begin
            s_d.reload_hi = i_wdata;
        end
        if (i_wr && (i_addr == RCT_ADDR_CKSEL)) begin
            s_d.cksel = i_wdata[1:0] & RCT_CKS_MASK;
        end
        // a capture beats a same-cycle software reload write
        if (s_q.cap_pulse) begin
            s_d.reload_lo = lo_count; // [R17]
            s_d.reload_hi = hi_count; // [R17]
        end
        // flags: hardware set wins over a software clear
        if (hi_wrap || s_q.cap_pulse) begin
            s_d.ctrl[RCT_CTL_HI_OVF] = 1'b1; // [R06] [R11] [R17]
        end
        if (lo_wrap) begin
            s_d.ctrl[RCT_CTL_LO_OVF] = 1'b1; // [R11] [R13]
        end
        // level request from the new flag values
        s_d.irq = i_tmr_irq_en && (s_d.ctrl[RCT_CTL_HI_OVF] ||
                  (s_d.ctrl[RCT_CTL_LO_IRQ] && s_d.ctrl[RCT_CTL_LO_OVF])); // [R06] [R07] [R12]
        // read data stands only in the cycle after the strobe
        s_d.rdata = RCT_BYTE_RST;
        if (i_rd) begin
            if (i_addr == RCT_ADDR_CTRL) begin
                s_d.rdata = s_q.ctrl;
            end else if (i_addr == RCT_ADDR_RLO) begin
                s_d.rdata = s_q.reload_lo;
            end else if (i_addr == RCT_ADDR_RHI) begin
                s_d.rdata = s_q.reload_hi;
            end else if (i_addr == RCT_ADDR_CLO) begin
                s_d.rdata = lo_count; // [R01]
            end else if (i_addr == RCT_ADDR_CHI) begin
                s_d.rdata = hi_count; // [R01]
            end else if (i_addr == RCT_ADDR_CKSEL) begin
                s_d.rdata = {6'h00, s_q.cksel};
            end else begin
                s_d.rdata = RCT_BYTE_RST; // unmapped reads zero
            end
        end
    end

    // state register; all reset values are zero
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata = s_q.rdata;
    assign o_irq = s_q.irq;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    logic [15:0] count16;  // joined count
    logic [15:0] reload16; // joined reload
    logic hi_flag;
    logic lo_flag;
    assign count16 = {hi_count, lo_count};
    assign reload16 = {s_q.reload_hi, s_q.reload_lo};
    assign hi_flag = s_q.ctrl[RCT_CTL_HI_OVF];
    assign lo_flag = s_q.ctrl[RCT_CTL_LO_OVF];

    sequence s_full_wrap;
        (mode == RCT_MODE_RELOAD16) && hi_wrap && !wr_clo && !wr_chi;
    endsequence

    property p_reload16;
        s_full_wrap |=> (count16 == $past(reload16));
    endproperty
    a_reload16: assert property (p_reload16) else $error("16-bit reload missed"); // [R05]

    property p_cap16_wrap;
        (mode == RCT_MODE_CAP16) && hi_wrap && !wr_clo && !wr_chi |=> count16 == 16'h0000;
    endproperty
    a_cap16_wrap: assert property (p_cap16_wrap) else $error("capture count not free"); // [R16]

    property p_split_lo_reload;
        (mode == RCT_MODE_SPLIT8) && lo_wrap && !wr_clo |=> lo_count == $past(s_q.reload_lo);
    endproperty
    a_split_lo_reload: assert property (p_split_lo_reload) else $error("low reload missed"); // [R08]

    property p_hi_gate;
        split && !run && !wr_chi |=> $stable(hi_count);
    endproperty
    a_hi_gate: assert property (p_hi_gate) else $error("high half ran while stopped"); // [R09]

    property p_lo_free;
        split && lo_tick && !lo_wrap && !wr_clo |=> lo_count == $past(lo_count) + RCT_BYTE_ONE;
    endproperty
    a_lo_free: assert property (p_lo_free) else $error("low half not counting"); // [R09]

    property p_hi_flag_set;
        hi_wrap |=> hi_flag;
    endproperty
    a_hi_flag_set: assert property (p_hi_flag_set) else $error("high flag not set"); // [R11]

    property p_flag_sticky;
        (hi_flag || lo_flag) && !wr_ctrl |=> $past(hi_flag) <= hi_flag && $past(lo_flag) <= lo_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hardware"); // [R13]

    property p_irq_level;
        hi_flag && i_tmr_irq_en && !wr_ctrl |=> o_irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt not raised"); // [R12]

    sequence s_capture;
        s_q.cap_pulse;
    endsequence

    property p_capture;
        s_capture |=> reload16 == $past(count16) && hi_flag;
    endproperty
    a_capture: assert property (p_capture) else $error("capture copy missed"); // [R17]

    property p_cap_single;
        s_capture |=> !s_q.cap_pulse;
    endproperty
    a_cap_single: assert property (p_cap_single) else $error("double capture pulse"); // [R20]

    property p_sys12;
        s_q.sys12_tick |=> !s_q.sys12_tick [*8] ##4 s_q.sys12_tick;
    endproperty
    a_sys12: assert property (p_sys12) else $error("divide by twelve off"); // [R03]

endmodule // rct_timer

// file: rct_pkg.sv
// constants, register map and mode codes of the reload/capture timer
// assumes an 8-bit register port and one 40 MHz core clock
package rct_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int RCT_DW = 8;   // register and half-counter width
    localparam int RCT_AW = 3;   // register address width

    // ************************************************************
    // register offsets on the plain port
    // ************************************************************
    localparam logic [RCT_AW-1:0] RCT_ADDR_CTRL  = 3'h0; // control_reg
    localparam logic [RCT_AW-1:0] RCT_ADDR_RLO   = 3'h1; // reload_low
    localparam logic [RCT_AW-1:0] RCT_ADDR_RHI   = 3'h2; // reload_high
    localparam logic [RCT_AW-1:0] RCT_ADDR_CLO   = 3'h3; // count_low
    localparam logic [RCT_AW-1:0] RCT_ADDR_CHI   = 3'h4; // count_high
    localparam logic [RCT_AW-1:0] RCT_ADDR_CKSEL = 3'h5; // clock_select_reg

    // ************************************************************
    // control_reg bit positions
    // ************************************************************
    localparam int RCT_CTL_HI_OVF  = 7; // hi_overflow_flag
    localparam int RCT_CTL_LO_OVF  = 6; // lo_overflow_flag
    localparam int RCT_CTL_LO_IRQ  = 5; // lo_irq_enable
    localparam int RCT_CTL_CAP_EN  = 4; // capture_enable_bit
    localparam int RCT_CTL_SPLIT   = 3; // split_mode_sel
    localparam int RCT_CTL_RUN     = 2; // high_run_ctl
    localparam int RCT_CTL_CAP_SRC = 1; // capture_source_sel
    localparam int RCT_CTL_EXT_CLK = 0; // ext_clk_sel

    // ************************************************************
    // clock_select_reg bit positions
    // ************************************************************
    localparam int RCT_CKS_LO_FAST = 0; // lo_clk_fast_sel
    localparam int RCT_CKS_HI_FAST = 1; // hi_clk_fast_sel
    localparam logic [1:0] RCT_CKS_MASK = 2'h3;

    // ************************************************************
    // reset values and limits
    // ************************************************************
    localparam logic [RCT_DW-1:0] RCT_BYTE_RST = 8'h00;
    localparam logic [RCT_DW-1:0] RCT_BYTE_MAX = 8'hFF;
    localparam logic [RCT_DW-1:0] RCT_BYTE_ONE = 8'h01;

    // ************************************************************
    // tick dividers
    // ************************************************************
    localparam logic [3:0] RCT_SYS_DIV_MAX = 4'hB; // core_clock / 12
    localparam logic [3:0] RCT_SYS_DIV_ONE = 4'h1;
    localparam logic [2:0] RCT_EXT_DIV_MAX = 3'h7; // ext osc / 8
    localparam logic [2:0] RCT_EXT_DIV_ONE = 3'h1;
    localparam logic RCT_SRC_SOF = 1'b0;           // capture source codes
    localparam logic RCT_SRC_LFO = 1'b1;

    // ************************************************************
    // operating modes
    // ************************************************************
    typedef enum logic [1:0] {
        RCT_MODE_RELOAD16,
        RCT_MODE_SPLIT8,
        RCT_MODE_CAP16,
        RCT_MODE_CAP8
    } rct_mode_t;

endpackage

// file: rct_half8.sv
// one 8-bit half of the timer: increment, reload, software load
// assumes the parent supplies one-cycle increment enables
`timescale 1ns/100ps
module rct_half8
    import rct_pkg::*;
#(
    parameter int W = RCT_DW
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_inc,              // count enable, one cycle
    input wire logic i_reload_now,       // reload instead of wrap to zero
    input wire logic [W-1:0] i_reload,   // reload value
    input wire logic i_wr,               // software write of the count
    input wire logic [W-1:0] i_wdata,
    output logic [W-1:0] o_count,
    output logic o_wrap                  // increment at all ones
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [W-1:0] count; // current count
    } rct_half_t;

    rct_half_t s_q; // registered state
    rct_half_t s_d; // next state

    // wrap is combinational so the high half can chain in the same cycle
    assign o_wrap = i_inc && (s_q.count == W'(RCT_BYTE_MAX));
    assign o_count = s_q.count;

    // next-state logic; a software write beats counting
    always_comb begin
        s_d = s_q;
        if (i_wr) begin
            s_d.count = i_wdata;
        end else if (o_wrap) begin
            // reload on overflow, or plain wrap to zero
            s_d.count = i_reload_now ? i_reload : W'(RCT_BYTE_RST); // [R05] [R16] [R18]
        end else if (i_inc) begin
            s_d.count = s_q.count + W'(RCT_BYTE_ONE);
        end
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule // rct_half8

// file: tb.sv
// self-checking bench for the reload/capture timer
// assumes rct_pkg compiled first and the timer's own assertions in its body
`timescale 1ns/100ps
module tb;
    import rct_pkg::*;
    // ************************************************************
    // stimulus and observation
    // ************************************************************
    logic i_clk = 1'b0; // 40 MHz core clock
    logic i_srst = 1'b1; // held for 6 cycles
    logic [RCT_AW-1:0] i_addr = '0;
    logic [RCT_DW-1:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_tmr_irq_en = 1'b1; // interrupts enabled throughout
    logic i_ext_osc = 1'b0;
    logic i_low_freq_osc = 1'b0;
    logic i_usb_sof = 1'b0;
    logic [RCT_DW-1:0] o_rdata;
    logic o_irq;
    logic [RCT_DW-1:0] rv; // last read value
    int num_errors = 0;
    int samples_checked = 0;
    // register table rows: written value and what reads back
    typedef struct {logic [RCT_AW-1:0] a; logic [7:0] w; logic [7:0] e;} rct_row_t;
    rct_row_t rows[7] = '{'{3'h1, 8'hA5, 8'hA5}, '{3'h2, 8'h5A, 8'h5A}, '{3'h3, 8'h3C, 8'h3C},
        '{3'h4, 8'hC3, 8'hC3}, '{3'h5, 8'hFF, 8'h03}, '{3'h6, 8'hFF, 8'h00}, '{3'h7, 8'h11, 8'h00}};

    always #12.5 i_clk = ~i_clk; // half period of 12.5 ns

    rct_timer u_rct_timer (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_tmr_irq_en(i_tmr_irq_en), .i_ext_osc(i_ext_osc),
        .i_low_freq_osc(i_low_freq_osc), .i_usb_sof(i_usb_sof), .o_rdata(o_rdata),
        .o_irq(o_irq));

    // ************************************************************
    // bus tasks and compares
    // ************************************************************
    // one-cycle write strobe
    task automatic wr(input logic [RCT_AW-1:0] a, input logic [7:0] d);
        @(posedge i_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
        @(posedge i_clk) i_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [RCT_AW-1:0] a);
        @(posedge i_clk) {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_clk) i_rd <= 1'b0;
        #1 rv = o_rdata;
    endtask
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %b seen %b", n, e, g);
        end
    endtask
    // bounded wait for the interrupt level; running out is a mismatch
    task automatic wait_irq(input logic e, input int bound);
        int n;
        n = 0;
        while (o_irq !== e && n < bound) begin
            @(posedge i_clk);
            #1 n++;
        end
        chk1("irq_wait", e, o_irq);
        if (o_irq !== e) close_out();
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (6) @(posedge i_clk);
        i_srst <= 1'b0;
        // reset values of every register
        for (int a = 0; a < 6; a++) begin
            rd(a[RCT_AW-1:0]);
            chk8("reset_val", 8'h00, rv);
        end
        // table: counter stopped, so count halves read back as written
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a);
            chk8("reg_rw", rows[i].e, rv);
        end
        // 16-bit reload at full speed
        wr(RCT_ADDR_CKSEL, 8'h01);
        wr(RCT_ADDR_RLO, 8'h34);
        wr(RCT_ADDR_RHI, 8'h12);
        wr(RCT_ADDR_CLO, 8'hF0);
        wr(RCT_ADDR_CHI, 8'hFF);
        wr(RCT_ADDR_CTRL, 8'h04);
        wait_irq(1'b1, 40);
        rd(RCT_ADDR_CHI);
        chk8("reload_hi", 8'h12, rv);
        repeat (20) @(posedge i_clk);
        rd(RCT_ADDR_CTRL);
        chk1("hi_flag_held", 1'b1, rv[RCT_CTL_HI_OVF]);
        wr(RCT_ADDR_CTRL, 8'h00);
        wait_irq(1'b0, 4);
        // low-byte interrupt in 16-bit mode, high flag stays clear
        wr(RCT_ADDR_CTRL, 8'h24);
        wait_irq(1'b1, 300);
        rd(RCT_ADDR_CTRL);
        chk8("ctl_lo_wrap", 8'h64, rv);
        // split mode, high half stopped
        wr(RCT_ADDR_CTRL, 8'h00);
        wr(RCT_ADDR_CHI, 8'h77);
        wr(RCT_ADDR_RLO, 8'h50);
        wr(RCT_ADDR_CLO, 8'hFE);
        wr(RCT_ADDR_CTRL, 8'h08);
        repeat (10) @(posedge i_clk);
        rd(RCT_ADDR_CHI);
        chk8("hi_gated", 8'h77, rv);
        rd(RCT_ADDR_CLO);
        chk1("lo_reload", 1'b1, rv >= 8'h50 && rv < 8'h60);
        rd(RCT_ADDR_CTRL);
        chk8("ctl_split", 8'h48, rv);
        chk1("irq_lo_masked", 1'b0, o_irq);
        wr(RCT_ADDR_CTRL, 8'h28);
        wait_irq(1'b1, 300);
        // high half running at full speed, reloads from reload_high
        wr(RCT_ADDR_CKSEL, 8'h03);
        wr(RCT_ADDR_RHI, 8'h90);
        wr(RCT_ADDR_CHI, 8'hFE);
        wr(RCT_ADDR_CTRL, 8'h0C);
        repeat (6) @(posedge i_clk);
        rd(RCT_ADDR_CHI);
        chk1("hi_reload", 1'b1, rv >= 8'h90 && rv < 8'hA0);
        rd(RCT_ADDR_CTRL);
        chk1("hi_flag_split", 1'b1, rv[RCT_CTL_HI_OVF]);
        // core clock divided by 12
        wr(RCT_ADDR_CTRL, 8'h00);
        wr(RCT_ADDR_CKSEL, 8'h00);
        wr(RCT_ADDR_CLO, 8'h00);
        wr(RCT_ADDR_CHI, 8'h00);
        wr(RCT_ADDR_CTRL, 8'h04);
        repeat (120) @(posedge i_clk);
        rd(RCT_ADDR_CLO);
        chk1("div12", 1'b1, rv >= 8'h09 && rv <= 8'h0B);
        // external oscillator divided by 8, edges driven on the core clock
        wr(RCT_ADDR_CTRL, 8'h00);
        wr(RCT_ADDR_CLO, 8'h00);
        wr(RCT_ADDR_CTRL, 8'h05);
        // pin taken as synchronous: one rising edge every two cycles
        repeat (64) begin
            @(posedge i_clk) i_ext_osc <= 1'b1;
            @(posedge i_clk) i_ext_osc <= 1'b0;
        end
        repeat (6) @(posedge i_clk);
        rd(RCT_ADDR_CLO);
        chk1("ext_div8", 1'b1, rv >= 8'h07 && rv <= 8'h08);
        // frame-start capture with the count frozen
        wr(RCT_ADDR_CTRL, 8'h00);
        wr(RCT_ADDR_CLO, 8'hCD);
        wr(RCT_ADDR_CHI, 8'hAB);
        wr(RCT_ADDR_CTRL, 8'h10);
        @(posedge i_clk) i_usb_sof <= 1'b1;
        @(posedge i_clk) i_usb_sof <= 1'b0;
        wait_irq(1'b1, 6);
        rd(RCT_ADDR_RLO);
        chk8("cap_lo", 8'hCD, rv);
        rd(RCT_ADDR_RHI);
        chk8("cap_hi", 8'hAB, rv);
        // oscillator-edge capture, one capture per edge, frame start ignored
        wr(RCT_ADDR_CTRL, 8'h12);
        wr(RCT_ADDR_CLO, 8'h57);
        wr(RCT_ADDR_CHI, 8'h13);
        @(posedge i_clk) i_low_freq_osc <= 1'b1;
        repeat (6) @(posedge i_clk);
        rd(RCT_ADDR_RLO);
        chk8("lfo_cap", 8'h57, rv);
        wr(RCT_ADDR_CLO, 8'h00);
        @(posedge i_clk) i_usb_sof <= 1'b1;
        @(posedge i_clk) i_usb_sof <= 1'b0;
        repeat (6) @(posedge i_clk);
        rd(RCT_ADDR_RLO);
        chk8("one_cap", 8'h57, rv);
        // capture split mode: low half wraps to zero, never reloads
        wr(RCT_ADDR_CKSEL, 8'h01);
        wr(RCT_ADDR_CLO, 8'hFE);
        wr(RCT_ADDR_CTRL, 8'h18);
        repeat (4) @(posedge i_clk);
        rd(RCT_ADDR_CLO);
        chk1("cap8_free", 1'b1, rv < 8'h10);
        rd(RCT_ADDR_CTRL);
        chk1("cap8_lo_flag", 1'b1, rv[RCT_CTL_LO_OVF]);
        // read data falls back to zero one cycle after it stood
        @(posedge i_clk);
        #1 chk8("rdata_idle", 8'h00, o_rdata);
        close_out();
    end
endmodule // tb
